// ### verilog/sr1_shadow_pair.sv
// Status register one non-volatile/volatile pair behind an SPI command port
`timescale 1ns/1ps

// Overview of operation
// - Hardware and software resets copy the non-volatile register into the volatile register; rst_n loads both with the shipped value.
// - Non-volatile write erases, reprograms, then refreshes volatile copy from it.
// - Reads of either register return the volatile copy.
// - Volatile write changes only volatile copy bits; non-volatile copy untouched.
// - Shipped non-volatile defaults are all zero.
// - Non-volatile bits 1 and 0 are read-only defaults, host cannot alter.
// - Lock bit set and protect pin low refuses the register write commands 01h and 71h.
// - Lock bit clear means no register write protection whatever the pin.
// - Bit 6 picks range origin: 1 bottom, 0 top.
// - Bits 5..2 select protected range; reset value from non-volatile copy.
// - Write enable latch gates any embedded operation start.
// - Latch set only by enable and volatile enable; cleared by disable, clear-status, resets, volatile write and operation end.
// - Busy bit shows embedded operation; non-volatile register writes set it directly, volatile writes do not.
// - Codes: read status 05h, register write 01h, read any 65h.
// - Codes: enable 06h, disable 04h, volatile enable 50h, clear 30h, write any 71h.
// - While busy, only reads, suspend, clear-status and reset pair are accepted.
// - Successful program, register write or erase clears the write enable latch.
module sr1_shadow_pair
  import sr1_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       hw_reset_n,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic       wp_n,
  input  wire logic       op_request,
  output logic            miso,
  output logic            miso_oe,
  output logic            op_started,
  output logic [7:0]      status_one_volatile_out,
  output logic [7:0]      status_one_nonvolatile_out
);
  // Input synchronisers: two flops for each pin
  logic [4:0] sync1, sync2;
  logic       sck_d;
  always_ff @(posedge clk) begin
    sync1 <= {hw_reset_n, sck, cs_n, mosi, wp_n};
    sync2 <= sync1;
    sck_d <= sync2[3];
  end
  logic hwr_s, sck_s, cs_s, mosi_s, wp_s;
  assign {hwr_s, sck_s, cs_s, mosi_s, wp_s} = sync2;
  logic sck_rise, sck_fall;
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;

  sr1_status_t vol, next_vol;
  logic [7:0]  nv, next_nv, pend, next_pend;
  sr1_state_t  state, next_state;
  logic [7:0]  shreg, next_shreg, cmd, next_cmd;
  logic [2:0]  bitcnt, next_bitcnt;
  logic [1:0]  acnt, next_acnt;
  logic        asel_vol, next_asel_vol;
  logic [15:0] busy_cnt, next_busy_cnt;
  logic        nv_busy, next_nv_busy;
  logic        rst_armed, next_rst_armed;
  logic        miso_q, next_miso, miso_oe_q, next_miso_oe, op_q, next_op;

  logic locked, busy_ok;
  assign locked = vol.reg_lock & ~wp_s;
  always_comb begin
    unique case (cmd)
      SR1_CMD_READ_STATUS_ONE, SR1_CMD_READ_ANY_REG, SR1_CMD_SUSPEND,
      SR1_CMD_CLEAR_STATUS, SR1_CMD_READ_CONFIG_ONE, SR1_CMD_READ_STATUS_TWO,
      SR1_CMD_READ_CONFIG_TWO, SR1_CMD_READ_CONFIG_THR, SR1_CMD_RESET_ENABLE,
      SR1_CMD_RESET: busy_ok = 1'b1;
      default: busy_ok = ~vol.busy_flag;
    endcase
  end

  always_comb begin
    next_vol       = vol;
    next_nv        = nv;
    next_pend      = pend;
    next_state     = state;
    next_shreg     = shreg;
    next_cmd       = cmd;
    next_bitcnt    = bitcnt;
    next_acnt      = acnt;
    next_asel_vol  = asel_vol;
    next_busy_cnt  = busy_cnt;
    next_nv_busy   = nv_busy;
    next_rst_armed = rst_armed;
    next_miso      = miso_q;
    next_miso_oe   = miso_oe_q;
    next_op        = 1'b0;
    // Embedded operation timing
    if (vol.busy_flag && busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - 16'h0001;
    end else if (vol.busy_flag) begin
      if (nv_busy) begin
        next_nv = pend;
        next_vol = sr1_status_t'({pend[7:2], 2'b00});
        next_nv_busy = 1'b0;
      end
      next_vol.busy_flag = 1'b0;
      next_vol.write_enable_latch = 1'b0;
    end
    // Embedded operation start, gated by the latch
    if (op_request && vol.write_enable_latch && !vol.busy_flag) begin
      next_vol.busy_flag = 1'b1;
      next_busy_cnt = SR1_OP_BUSY_CYCLES;
      next_op = 1'b1;
    end
    if (cs_s) begin
      next_state   = SR1_CMD;
      next_bitcnt  = '0;
      next_miso_oe = 1'b0;
    end else if (sck_rise) begin
      next_shreg = {shreg[6:0], mosi_s};
      next_bitcnt = bitcnt + 3'h1;
      if (bitcnt == SR1_BITS_CMD) begin
        unique case (state)
          SR1_CMD: begin
            next_cmd = {shreg[6:0], mosi_s};
            next_state = SR1_WAIT;
            unique case ({shreg[6:0], mosi_s})
              SR1_CMD_READ_STATUS_ONE: next_state = SR1_READ;
              SR1_CMD_REGISTER_WRITE:  next_state = SR1_DATA;
              SR1_CMD_READ_ANY_REG, SR1_CMD_WRITE_ANY_REG: begin
                next_state = SR1_ADDR;
                next_acnt  = '0;
              end
              default: next_state = SR1_WAIT;
            endcase
          end
          SR1_ADDR: begin
            if (acnt == 2'h0) begin
              next_asel_vol = shreg[6] == SR1_ADDR_VOLATILE[23];
            end
            next_acnt = acnt + 2'h1;
            if (acnt == 2'h2) begin
              next_state = (cmd == SR1_CMD_READ_ANY_REG) ? SR1_READ : SR1_DATA;
            end
          end
          SR1_DATA: begin
            next_state = SR1_WAIT;
            next_pend = {shreg[6:0], mosi_s};
          end
          default: next_state = state;
        endcase
      end
    end else if (sck_fall && state == SR1_READ) begin
      next_miso = vol[SR1_BIT_REG_LOCK - 32'(bitcnt)];
      next_miso_oe = 1'b1;
    end
    // Command executes when the frame ends
    if (cs_s && state == SR1_WAIT && bitcnt == '0 && busy_ok) begin
      next_state = SR1_IDLE;
      unique case (cmd)
        SR1_CMD_WRITE_ENABLE_NV, SR1_CMD_WRITE_ENABLE_V:
          next_vol.write_enable_latch = 1'b1;
        SR1_CMD_WRITE_DISABLE, SR1_CMD_CLEAR_STATUS: begin
          next_vol.write_enable_latch = 1'b0;
          // Busy of a pending non-volatile update is kept
          if (cmd == SR1_CMD_CLEAR_STATUS && !nv_busy) begin
            next_vol.busy_flag = 1'b0;
          end
        end
        SR1_CMD_RESET_ENABLE: next_rst_armed = 1'b1;
        SR1_CMD_RESET: begin
          if (rst_armed) begin
            next_vol     = sr1_status_t'(nv);
            next_nv_busy = 1'b0;
          end
        end
        SR1_CMD_REGISTER_WRITE, SR1_CMD_WRITE_ANY_REG: begin
          if (vol.write_enable_latch && !locked) begin
            if (cmd == SR1_CMD_WRITE_ANY_REG && asel_vol) begin
              next_vol = sr1_status_t'((vol & ~SR1_USER_MASK)
                                       | (pend & SR1_USER_MASK));
              next_vol.write_enable_latch = 1'b0;
            end else begin
              next_pend = (pend & SR1_USER_MASK) | (nv & ~SR1_USER_MASK);
              next_nv_busy = 1'b1;
              next_vol.busy_flag = 1'b1;
              next_busy_cnt = SR1_NV_BUSY_CYCLES;
            end
          end
        end
        default: next_vol = next_vol;
      endcase
      if (cmd != SR1_CMD_RESET_ENABLE) next_rst_armed = 1'b0;
    end else if (cs_s && state != SR1_CMD) begin
      next_state = SR1_CMD;
    end
    if (!hwr_s) begin
      next_vol = sr1_status_t'(nv);
      next_nv_busy = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nv        <= SR1_SHIP_VALUE;
      vol       <= sr1_status_t'(SR1_SHIP_VALUE);
      pend      <= SR1_SHIP_VALUE;
      state     <= SR1_IDLE;
      shreg     <= '0;
      cmd       <= '0;
      bitcnt    <= '0;
      acnt      <= '0;
      asel_vol  <= 1'b0;
      busy_cnt  <= '0;
      nv_busy   <= 1'b0;
      rst_armed <= 1'b0;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
      op_q      <= 1'b0;
      status_one_volatile_out    <= '0;
      status_one_nonvolatile_out <= '0;
    end else begin
      nv        <= next_nv;
      vol       <= next_vol;
      pend      <= next_pend;
      state     <= next_state;
      shreg     <= next_shreg;
      cmd       <= next_cmd;
      bitcnt    <= next_bitcnt;
      acnt      <= next_acnt;
      asel_vol  <= next_asel_vol;
      busy_cnt  <= next_busy_cnt;
      nv_busy   <= next_nv_busy;
      rst_armed <= next_rst_armed;
      miso_q    <= next_miso;
      miso_oe_q <= next_miso_oe;
      op_q      <= next_op;
      status_one_volatile_out    <= next_vol;
      status_one_nonvolatile_out <= next_nv;
    end
  end
  assign miso    = miso_q;
  assign miso_oe = miso_oe_q;
  assign op_started = op_q;

  // Checks
  nv_ro_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    nv[1:0] == 2'b00) else $error("nv default bits altered");
  lock_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (locked && $past(locked) && !nv_busy && !$past(nv_busy) && hwr_s && $past(hwr_s))
    |-> nv == $past(nv)) else $error("locked nv changed");
  op_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_q |-> $past(vol.write_enable_latch)) else $error("op without latch");
  nv_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    nv_busy |-> vol.busy_flag) else $error("nv update not busy");
  nv_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(nv_busy) && hwr_s) |-> vol[7:2] == nv[7:2]) else $error("no refresh");
  wel_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(vol.busy_flag) && hwr_s && !cs_s) |-> !vol.write_enable_latch)
    else $error("latch kept");
  hw_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !hwr_s |=> vol[7:2] == $past(nv[7:2])) else $error("no reset copy");
  miso_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(miso_oe_q) |-> miso_q == $past(vol.reg_lock)) else $error("bad read bit");
  wel_change_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(vol.write_enable_latch)
    |-> ($past(cmd) == SR1_CMD_WRITE_ENABLE_NV || $past(cmd) == SR1_CMD_WRITE_ENABLE_V))
    else $error("latch set by other command");
  busy_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(vol.busy_flag)
    |-> (op_q || nv_busy))
    else $error("busy set without operation");
  vol_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_s && state == SR1_WAIT && cmd == SR1_CMD_WRITE_ANY_REG && asel_vol && !nv_busy)
    |=> nv == $past(nv))
    else $error("volatile write changed nv");
  busy_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (vol.busy_flag && busy_cnt != '0 && cs_s && state == SR1_WAIT && cmd == SR1_CMD_WRITE_DISABLE)
    |=> vol.write_enable_latch == $past(vol.write_enable_latch))
    else $error("command taken while busy");
  soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_s && state == SR1_WAIT && bitcnt == '0 && busy_ok && cmd == SR1_CMD_RESET && rst_armed)
    |=> vol == $past(nv))
    else $error("soft reset copy missing");
  ship_reset_a: assert property (@(posedge clk)
    !rst_n
    |=> nv == SR1_SHIP_VALUE)
    else $error("nv not shipped value");
  out_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    status_one_volatile_out == vol
    && status_one_nonvolatile_out == nv)
    else $error("register outputs differ");
  nv_write_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(nv_busy)
    |-> $past(!locked && vol.write_enable_latch))
    else $error("nv write not gated");
  cov_nv_c: cover property (@(posedge clk) $fell(nv_busy));
  cov_lock_c: cover property (@(posedge clk)
    locked && cs_s && state == SR1_WAIT && cmd == SR1_CMD_WRITE_ANY_REG);
  cov_soft_rst_c: cover property (@(posedge clk)
    cs_s && state == SR1_WAIT && cmd == SR1_CMD_RESET && rst_armed);
  cov_op_c: cover property (@(posedge clk) op_q);
  cov_read_c: cover property (@(posedge clk) $rose(miso_oe_q));
endmodule // sr1_shadow_pair

// ### verilog/sr1_pkg.sv
// Package for the status register one shadow pair
package sr1_pkg;
  localparam logic [7:0] SR1_CMD_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] SR1_CMD_REGISTER_WRITE  = 8'h01;
  localparam logic [7:0] SR1_CMD_READ_ANY_REG    = 8'h65;
  localparam logic [7:0] SR1_CMD_WRITE_ANY_REG   = 8'h71;
  localparam logic [7:0] SR1_CMD_WRITE_ENABLE_NV = 8'h06;
  localparam logic [7:0] SR1_CMD_WRITE_DISABLE   = 8'h04;
  localparam logic [7:0] SR1_CMD_WRITE_ENABLE_V  = 8'h50;
  localparam logic [7:0] SR1_CMD_CLEAR_STATUS    = 8'h30;
  localparam logic [7:0] SR1_CMD_RESET_ENABLE    = 8'h66;
  localparam logic [7:0] SR1_CMD_RESET           = 8'h99;
  localparam logic [7:0] SR1_CMD_SUSPEND         = 8'h75;
  localparam logic [7:0] SR1_CMD_READ_CONFIG_ONE = 8'h35;
  localparam logic [7:0] SR1_CMD_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] SR1_CMD_READ_CONFIG_TWO = 8'h15;
  localparam logic [7:0] SR1_CMD_READ_CONFIG_THR = 8'h33;
  // Register address of status register one pair for the any-register commands
  localparam logic [23:0] SR1_ADDR_NONVOLATILE   = 24'h000000;
  localparam logic [23:0] SR1_ADDR_VOLATILE      = 24'h800000;
  // Field positions
  localparam int SR1_BIT_REG_LOCK     = 7;
  localparam int SR1_BIT_RANGE_ORIGIN = 6;
  localparam int SR1_BIT_WEL          = 1;
  localparam int SR1_BIT_BUSY         = 0;
  localparam logic [7:0] SR1_USER_MASK  = 8'hfc;
  localparam logic [7:0] SR1_SHIP_VALUE = 8'h00;
  localparam logic [2:0] SR1_BITS_CMD   = 3'h7;
  // Non-volatile erase plus program time, in clk cycles
  localparam logic [15:0] SR1_NV_BUSY_CYCLES = 16'h0100;
  localparam logic [15:0] SR1_OP_BUSY_CYCLES = 16'h0040;

  typedef enum {SR1_IDLE, SR1_CMD, SR1_ADDR, SR1_DATA, SR1_READ, SR1_WAIT} sr1_state_t;

  typedef struct packed {
    logic reg_lock;
    logic range_origin;
    logic [3:0] range_sel;
    logic write_enable_latch;
    logic busy_flag;
  } sr1_status_t;
endpackage

// ### verification/sr1_host.sv
// SPI host model issuing status register commands
`timescale 1ns/1ps
module sr1_host
  import sr1_pkg::*;
(
  input  wire logic clk,
  input  wire logic miso,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One framed command, MSB first, mode 0; rx keeps the last byte read
  task automatic xfer(input logic [7:0] q[$], output logic [7:0] rx);
    @(posedge clk) cs_n <= 1'b0;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        mosi <= q[i][b];
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        rx = {rx[6:0], miso};
        repeat (4) @(posedge clk);
        sck <= 1'b0;
      end
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
  endtask
endmodule // sr1_host

// ### verification/sr1_shadow_pair_tb.sv
// Testbench for the status register one shadow pair
`timescale 1ns/1ps
module sr1_shadow_pair_tb;
  import sr1_pkg::*;
  logic       clk, rst_n, hw_reset_n, wp_n, op_request;
  logic       sck, cs_n, mosi, miso, miso_oe, op_started;
  logic [7:0] vol, nv, rx;
  int         bad_count, checks_done;
  sr1_shadow_pair uut (.clk(clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n), .op_request(op_request), .miso(miso),
    .miso_oe(miso_oe), .op_started(op_started), .status_one_volatile_out(vol),
    .status_one_nonvolatile_out(nv));
  sr1_host host (.clk(clk), .miso(miso), .sck(sck), .cs_n(cs_n), .mosi(mosi));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (vol[0] !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    check(n < 600, 1'b1);
  endtask
  task automatic vwrite(input logic [7:0] d);
    host.xfer({SR1_CMD_WRITE_ENABLE_V}, rx);
    host.xfer({SR1_CMD_WRITE_ANY_REG, 8'h80, 8'h00, 8'h00, d}, rx);
  endtask
  task automatic t_ship;
    check(nv, SR1_SHIP_VALUE);
    check(vol, 8'h00);
    $display("t_ship done");
  endtask
  task automatic t_latch;
    logic [7:0] c [4] = '{SR1_CMD_WRITE_ENABLE_NV, SR1_CMD_WRITE_DISABLE,
                          SR1_CMD_WRITE_ENABLE_V, SR1_CMD_CLEAR_STATUS};
    foreach (c[i]) begin
      host.xfer({c[i]}, rx);
      check(vol, {6'h00, ~i[0], 1'b0});
    end
    $display("t_latch done");
  endtask
  task automatic t_nv_write;
    host.xfer({SR1_CMD_WRITE_ENABLE_NV}, rx);
    host.xfer({SR1_CMD_REGISTER_WRITE, 8'hff}, rx);
    check(vol, 8'h03);
    host.xfer({SR1_CMD_WRITE_DISABLE}, rx);
    check(vol, 8'h03);
    wait_idle();
    check(nv, 8'hfc);
    check(vol, 8'hfc);
    host.xfer({SR1_CMD_READ_ANY_REG, 8'h00, 8'h00, 8'h00, 8'h00}, rx);
    check(rx, 8'hfc);
    $display("t_nv_write done");
  endtask
  task automatic t_lock;
    @(posedge clk) wp_n <= 1'b0;
    vwrite(8'h00);
    check({vol[7:2], 2'b00}, 8'hfc);
    @(posedge clk) wp_n <= 1'b1;
    vwrite(8'h00);
    check(vol, 8'h00);
    check(nv, 8'hfc);
    @(posedge clk) wp_n <= 1'b0;
    vwrite(8'hab);
    check(vol, 8'ha8);
    host.xfer({SR1_CMD_READ_STATUS_ONE, 8'h00}, rx);
    check(rx, 8'ha8);
    check(miso_oe, 1'b0);
    $display("t_lock done");
  endtask
  task automatic t_op;
    int n;
    n = 0;
    @(posedge clk) op_request <= 1'b1;
    repeat (8) @(posedge clk) if (op_started === 1'b1) n++;
    op_request <= 1'b0;
    check(n, 0);
    host.xfer({SR1_CMD_WRITE_ENABLE_NV}, rx);
    @(posedge clk) op_request <= 1'b1;
    repeat (8) @(posedge clk) if (op_started === 1'b1) n++;
    op_request <= 1'b0;
    check(n, 1);
    check(vol, 8'hab);
    wait_idle();
    check(vol, 8'ha8);
    $display("t_op done");
  endtask
  task automatic t_resets;
    @(posedge clk) hw_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    hw_reset_n <= 1'b1;
    wp_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(vol, 8'hfc);
    vwrite(8'h00);
    check(vol, 8'h00);
    host.xfer({SR1_CMD_RESET_ENABLE}, rx);
    host.xfer({SR1_CMD_RESET}, rx);
    check(vol, 8'hfc);
    $display("t_resets done");
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    hw_reset_n = 1'b1;
    wp_n = 1'b1;
    op_request = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_ship();
    t_latch();
    t_nv_write();
    t_lock();
    t_op();
    t_resets();
    final_report();
  end
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
endmodule // sr1_shadow_pair_tb
